// ### hdl/cca_pkg.sv
// Constants, types and register map of the command channel arbiter.
// Assumes one 20 MHz clock domain shared with the request decoder and the starter core.
package cca_pkg;

    // Clock rate
    localparam int unsigned CLK_HZ              = 20_000_000;

    // Register addresses (Modbus page/low byte combined)
    localparam logic [15:0] CMD_WORD_ADDR       = 16'h02f0;
    localparam logic [15:0] CHAN_SEL_ADDR       = 16'h0191;
    localparam logic [15:0] FW_VERSION_ADDR     = 16'h0192;

    // Reset values
    localparam logic [15:0] CMD_WORD_RST        = 16'h0000;
    localparam logic [15:0] CHAN_SEL_RST        = 16'h0000;

    // Channel select values
    localparam logic [15:0] CHAN_LOCAL          = 16'h0000;
    localparam logic [15:0] CHAN_REMOTE         = 16'h0001;

    // Command word field positions
    localparam int unsigned CW_RUN_BIT          = 0;
    localparam int unsigned CW_TRIP_RESET_BIT   = 3;
    localparam int unsigned CW_FREEWHEEL_BIT    = 10;
    localparam int unsigned CW_SECOND_SET_BIT   = 11;
    localparam int unsigned CW_FORCE_LOCAL_BIT  = 15;

    // Modbus function codes
    localparam logic [7:0]  FN_READ_HOLDING     = 8'h03;
    localparam logic [7:0]  FN_WRITE_SINGLE     = 8'h06;
    localparam logic [7:0]  FN_WRITE_MULTIPLE   = 8'h10;

    // Modbus exception codes
    localparam logic [7:0]  EXC_NONE            = 8'h00;
    localparam logic [7:0]  EXC_ILLEGAL_FUNC    = 8'h01;
    localparam logic [7:0]  EXC_ILLEGAL_ADDR    = 8'h02;

    // Firmware version, four BCD digits: version then sub-version (arbitrary value)
    localparam logic [15:0] FW_VERSION_DEFAULT  = 16'h0101;

    // Forced-local input assignment
    typedef enum logic [1:0] {
        CCA_FL_NONE,
        CCA_FL_AUX_TWO,
        CCA_FL_AUX_THREE,
        CCA_FL_RESERVED
    } cca_fl_assign_t;

    // Utility menu item under the cursor
    typedef enum logic [1:0] {
        CCA_UT_SELF_TEST,
        CCA_UT_FACTORY_RESTORE,
        CCA_UT_HISTORY_CLEAR,
        CCA_UT_NONE
    } cca_utility_menu_item_t;

endpackage

// ### hdl/cca_command_channel_arbiter.sv
// Command channel arbiter: picks terminal or bus command source for a soft starter,
// serves decoded Modbus register requests and runs the utility menu actions.
// Assumes an upstream Modbus framer delivering one decoded single-register request
// at a time on the clk domain; terminal inputs arrive asynchronously from pins.
//
// What this block does
// R1: Channel select: 0 terminal control, 1 bus control; resets to 0.
// R2: Channel select changes accepted only while the motor is stopped.
// R3: Second or third auxiliary input can be assigned to forced local.
// R4: Assigned forced-local input counts as asserted at level 1.
// R5: Asserted forced-local input makes terminals the source regardless of channel select.
// R6: Forced local from input refuses bus function 6/16 writes with exception 1.
// R7: Bus parameter reads still served during forced local.
// R8: Forced-local input wins over command word bit 15.
// R9: Local mode: motor from terminals, parameters still bus readable and writable.
// R10: With bus active, only first-input stop is taken from terminals.
// R11: Bus commands act only while first logic input is 1.
// R12: Releasing first input during bus operation gives freewheel stop.
// R13: Master writes command word at 752 with function 6 or 16.
// R14: Bit 0 runs or stops with configured stop; bit 3 resets trip.
// R15: Bit 10 makes the bit 0 stop a freewheel stop.
// R16: Bit 11 selects the second parameter set.
// R17: Bit 15 forces local command onto the terminals.
// R18: Self test reports good or bad from internal fault sources.
// R19: Firmware version is read-only four digits: version, sub-version.
// R20: Factory restore and history clear need a second, confirming press.
// R21: History clear wipes run time, start, trip counters and nine trip entries.
// R22: Self test, restore and history clear accepted only while stopped.
// R23: Utility menu reachable except while the motor runs.
// R24: Reserved command word bits have no effect on motor control.

`timescale 1ns/1ns

module cca_command_channel_arbiter
    import cca_pkg::*;
#(
    parameter logic [15:0] FW_VERSION = FW_VERSION_DEFAULT
) (
    input  wire logic           clk,
    input  wire logic           reset,
    // Terminal pins
    input  wire logic           primary_run_input,
    input  wire logic           aux_input_two,
    input  wire logic           aux_input_three,
    // Configuration and starter state
    input  wire cca_fl_assign_t forced_local_assignment,
    input  wire logic           motor_stopped,
    input  wire logic           motor_running,
    // Decoded bus request
    input  wire logic           req_valid,
    input  wire logic [7:0]     req_func,
    input  wire logic [15:0]    req_addr,
    input  wire logic [15:0]    req_wdata,
    // Bus answer
    output logic                rsp_valid,
    output logic [7:0]          rsp_exception,
    output logic [15:0]         rsp_rdata,
    // Local keypad parameter write
    input  wire logic           kp_write,
    input  wire logic [15:0]    kp_addr,
    input  wire logic [15:0]    kp_wdata,
    // Utility menu keys
    input  wire cca_utility_menu_item_t utility_menu_item,
    input  wire logic           utility_menu_enter,
    input  wire logic [4:0]     self_test_faults,
    // Motor control outputs
    output logic                remote_active,
    output logic                forced_local,
    output logic                run_cmd,
    output logic                freewheel_stop,
    output logic                trip_reset,
    output logic                second_param_set,
    // Utility outputs
    output logic                utility_menu_open,
    output logic                utility_menu_confirm_prompt,
    output logic                self_test_done,
    output logic                self_test_good,
    output logic                factory_restore,
    output logic                history_counter_clear,
    output logic [15:0]         firmware_version
);

    typedef enum logic [1:0] {
        CCA_U_IDLE,
        CCA_U_CONFIRM_FACTORY,
        CCA_U_CONFIRM_HISTORY
    } cca_ustate_t;

    logic [1:0]     li1_sync_r;
    logic [1:0]     li2_sync_r;
    logic [1:0]     li3_sync_r;
    logic           li1;
    logic           fl_input;
    logic           bit15_local;
    logic [15:0]    cmd_word_r;
    logic [15:0]    chan_sel_r;
    logic           li1_prev_r;
    logic           li1_drop_fw_r;
    logic           bus_write;
    logic           bus_read;
    logic           cmd_hit;
    logic           chan_hit;
    logic           ver_hit;
    logic [7:0]     exc_nxt;
    logic [15:0]    rdata_nxt;
    logic           cmd_wr_ok;
    logic           chan_wr_bus;
    logic           chan_wr_kp;
    cca_ustate_t    ustate_r;
    cca_ustate_t    ustate_nxt;
    cca_utility_menu_item_t item_prev_r;
    logic           utility_menu_ok;

    // Two-flop synchronisers for the terminal pins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            li1_sync_r <= 2'h0;
            li2_sync_r <= 2'h0;
            li3_sync_r <= 2'h0;
        end else begin
            li1_sync_r <= {li1_sync_r[0], primary_run_input};
            li2_sync_r <= {li2_sync_r[0], aux_input_two};
            li3_sync_r <= {li3_sync_r[0], aux_input_three};
        end
    end

    assign li1 = li1_sync_r[1];

    // Forced-local input selection, active at level 1
    always_comb begin
        unique case (forced_local_assignment)
            CCA_FL_AUX_TWO:   fl_input = li2_sync_r[1]; // [R3] [R4]
            CCA_FL_AUX_THREE: fl_input = li3_sync_r[1]; // [R3] [R4]
            default:          fl_input = 1'b0;
        endcase
    end

    // Source selection: input force first, then bit 15, then channel select
    assign bit15_local   = cmd_word_r[CW_FORCE_LOCAL_BIT];                            // [R17]
    assign forced_local  = fl_input | bit15_local;                                     // [R8]
    assign remote_active = (chan_sel_r == CHAN_REMOTE) && !fl_input && !bit15_local;   // [R1] [R5]

    // Request decode
    assign bus_write = req_valid && (req_func == FN_WRITE_SINGLE || req_func == FN_WRITE_MULTIPLE);
    assign bus_read  = req_valid && (req_func == FN_READ_HOLDING);
    assign cmd_hit   = (req_addr == CMD_WORD_ADDR);
    assign chan_hit  = (req_addr == CHAN_SEL_ADDR);
    assign ver_hit   = (req_addr == FW_VERSION_ADDR);

    // Answer selection
    always_comb begin
        exc_nxt   = EXC_NONE;
        rdata_nxt = 16'h0000;
        if (bus_write) begin
            if (fl_input) begin
                exc_nxt = EXC_ILLEGAL_FUNC;                  // [R6]
            end else if (!(cmd_hit || chan_hit)) begin
                exc_nxt = EXC_ILLEGAL_ADDR;                  // [R19]
            end else begin
                rdata_nxt = req_wdata;                       // [R9] [R13]
            end
        end else if (bus_read) begin
            unique case (1'b1)
                cmd_hit:  rdata_nxt = cmd_word_r;            // [R7]
                chan_hit: rdata_nxt = chan_sel_r;            // [R7]
                ver_hit:  rdata_nxt = FW_VERSION;            // [R7] [R19]
                default:  exc_nxt   = EXC_ILLEGAL_ADDR;
            endcase
        end else begin
            exc_nxt = EXC_ILLEGAL_FUNC;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rsp_valid     <= 1'b0;
            rsp_exception <= EXC_NONE;
            rsp_rdata     <= 16'h0000;
        end else begin
            rsp_valid <= req_valid;
            if (req_valid) begin
                rsp_exception <= exc_nxt;
                rsp_rdata     <= rdata_nxt;
            end
        end
    end

    // Register writes
    assign cmd_wr_ok   = bus_write && !fl_input && cmd_hit;                       // [R6] [R13]
    assign chan_wr_bus = bus_write && !fl_input && chan_hit && motor_stopped;     // [R2] [R6]
    assign chan_wr_kp  = kp_write && (kp_addr == CHAN_SEL_ADDR) && motor_stopped; // [R2]

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            chan_sel_r <= CHAN_SEL_RST;                                           // [R1]
        end else if (chan_wr_kp) begin
            chan_sel_r <= (kp_wdata == CHAN_REMOTE) ? CHAN_REMOTE : CHAN_LOCAL;
        end else if (chan_wr_bus) begin
            chan_sel_r <= (req_wdata == CHAN_REMOTE) ? CHAN_REMOTE : CHAN_LOCAL;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_word_r <= CMD_WORD_RST;
        end else if (cmd_wr_ok) begin
            cmd_word_r <= req_wdata;
        end
    end

    // Trip reset pulse on a write with bit 3 set while the bus commands
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            trip_reset <= 1'b0;
        end else begin
            trip_reset <= cmd_wr_ok && req_wdata[CW_TRIP_RESET_BIT] && remote_active && li1; // [R14] [R11]
        end
    end

    // Freewheel latch for a first-input release during bus operation
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            li1_prev_r    <= 1'b0;
            li1_drop_fw_r <= 1'b0;
        end else begin
            li1_prev_r <= li1;
            if (remote_active && li1_prev_r && !li1) begin
                li1_drop_fw_r <= 1'b1;                       // [R12]
            end else if (li1) begin
                li1_drop_fw_r <= 1'b0;
            end
        end
    end

    // Motor control; reserved command bits are never looked at
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_cmd          <= 1'b0;
            freewheel_stop   <= 1'b0;
            second_param_set <= 1'b0;
        end else if (remote_active) begin
            run_cmd          <= li1 && cmd_word_r[CW_RUN_BIT];                 // [R10] [R11] [R14] [R24]
            freewheel_stop   <= !li1 || li1_drop_fw_r ||
                                (!cmd_word_r[CW_RUN_BIT] && cmd_word_r[CW_FREEWHEEL_BIT]); // [R12] [R15]
            second_param_set <= li1 && cmd_word_r[CW_SECOND_SET_BIT];          // [R16] [R11]
        end else begin
            run_cmd          <= li1;                                           // [R5] [R9]
            freewheel_stop   <= 1'b0;
            second_param_set <= 1'b0;
        end
    end

    // Utility menu
    assign utility_menu_open = !motor_running;                // [R23]
    assign utility_menu_ok           = utility_menu_enter && motor_stopped && !motor_running; // [R22]
    assign firmware_version  = FW_VERSION;                    // [R19]

    always_comb begin
        ustate_nxt = ustate_r;
        unique case (ustate_r)
            CCA_U_IDLE: begin
                if (utility_menu_ok && utility_menu_item == CCA_UT_FACTORY_RESTORE) begin
                    ustate_nxt = CCA_U_CONFIRM_FACTORY;       // [R20]
                end else if (utility_menu_ok && utility_menu_item == CCA_UT_HISTORY_CLEAR) begin
                    ustate_nxt = CCA_U_CONFIRM_HISTORY;       // [R20]
                end
            end
            CCA_U_CONFIRM_FACTORY,
            CCA_U_CONFIRM_HISTORY: begin
                if (!motor_stopped || motor_running || utility_menu_item != item_prev_r || utility_menu_ok) begin
                    ustate_nxt = CCA_U_IDLE;
                end
            end
            default: ustate_nxt = CCA_U_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ustate_r    <= CCA_U_IDLE;
            item_prev_r <= CCA_UT_NONE;
        end else begin
            ustate_r    <= ustate_nxt;
            item_prev_r <= utility_menu_item;
        end
    end

    assign utility_menu_confirm_prompt = (ustate_r != CCA_U_IDLE);

    // Action pulses on the second press
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            factory_restore       <= 1'b0;
            history_counter_clear <= 1'b0;
        end else begin
            factory_restore       <= (ustate_r == CCA_U_CONFIRM_FACTORY) && utility_menu_ok &&
                                     utility_menu_item == CCA_UT_FACTORY_RESTORE;       // [R20] [R22]
            history_counter_clear <= (ustate_r == CCA_U_CONFIRM_HISTORY) && utility_menu_ok &&
                                     utility_menu_item == CCA_UT_HISTORY_CLEAR;         // [R20] [R21]
        end
    end

    // Self test: any fault source gives a bad result
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            self_test_done <= 1'b0;
            self_test_good <= 1'b0;
        end else begin
            self_test_done <= utility_menu_ok && utility_menu_item == CCA_UT_SELF_TEST;         // [R22]
            if (utility_menu_ok && utility_menu_item == CCA_UT_SELF_TEST) begin
                self_test_good <= (self_test_faults == 5'h00);                  // [R18]
            end
        end
    end

endmodule // cca_command_channel_arbiter

// ### sim/cca_bus_master.sv
// Bus master model: issues decoded single-register requests to the arbiter.
// Assumes the answer stands for one cycle, one cycle after the request is taken.
`timescale 1ns/1ns
module cca_bus_master (
    input  wire logic        clk,
    output logic             req_valid,
    output logic [7:0]       req_func,
    output logic [15:0]      req_addr,
    output logic [15:0]      req_wdata,
    input  wire logic        rsp_valid,
    input  wire logic [7:0]  rsp_exception,
    input  wire logic [15:0] rsp_rdata
);
    logic ok;
    initial begin
        req_valid = 1'b0;
        req_func  = 8'h00;
        req_addr  = 16'h0000;
        req_wdata = 16'h0000;
    end
    // One register per request, answer caught in its only cycle
    task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                        output logic [7:0] exc, output logic [15:0] rd);
        @(posedge clk);
        req_valid <= 1'b1;
        req_func  <= f;
        req_addr  <= a;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        req_addr  <= ~a;
        req_wdata <= ~d;
        #1;
        ok  = rsp_valid;
        exc = rsp_exception;
        rd  = rsp_rdata;
    endtask
endmodule // cca_bus_master

// ### sim/cca_arbiter_properties.sv
// Checker of the command channel arbiter, bound to its top module.
// Assumes 2-cycle pin synchronisers and registered answers.
`timescale 1ns/1ns
module cca_arbiter_properties
    import cca_pkg::*;
#(
    parameter logic [15:0] FW_VERSION = FW_VERSION_DEFAULT
) (
    input wire logic           clk,
    input wire logic           reset,
    input wire logic           primary_run_input,
    input wire logic           aux_input_two,
    input wire logic           aux_input_three,
    input wire cca_fl_assign_t forced_local_assignment,
    input wire logic           motor_stopped,
    input wire logic           motor_running,
    input wire logic           req_valid,
    input wire logic [7:0]     req_func,
    input wire logic [15:0]    req_addr,
    input wire logic           rsp_valid,
    input wire logic [7:0]     rsp_exception,
    input wire logic [15:0]    rsp_rdata,
    input wire cca_utility_menu_item_t utility_menu_item,
    input wire logic           utility_menu_enter,
    input wire logic           remote_active,
    input wire logic           forced_local,
    input wire logic           run_cmd,
    input wire logic           freewheel_stop,
    input wire logic           trip_reset,
    input wire logic           utility_menu_open,
    input wire logic           utility_menu_confirm_prompt,
    input wire logic           self_test_done,
    input wire logic           factory_restore,
    input wire logic           history_counter_clear
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic fl_pin;
    logic wr_req;
    assign fl_pin = (forced_local_assignment == CCA_FL_AUX_TWO && aux_input_two)
                 || (forced_local_assignment == CCA_FL_AUX_THREE && aux_input_three);
    assign wr_req = req_valid && (req_func == FN_WRITE_SINGLE || req_func == FN_WRITE_MULTIPLE);
    sequence hist_enter;
        utility_menu_enter && motor_stopped && !motor_running && utility_menu_item == CCA_UT_HISTORY_CLEAR;
    endsequence
    sequence first_press;
        !utility_menu_confirm_prompt ##0 hist_enter;
    endsequence
    sequence second_press;
        utility_menu_confirm_prompt && $stable(utility_menu_item) ##0 hist_enter;
    endsequence
    AST_RSP_TIMING: assert property (req_valid |=> rsp_valid) else $error("answer missing");
    AST_FL_WRITE_REFUSED: assert property (fl_pin [*4] ##0 wr_req |=> rsp_exception == EXC_ILLEGAL_FUNC)
        else $error("write not refused in forced local");
    AST_READ_SERVED: assert property (req_valid && req_func == FN_READ_HOLDING && req_addr == CMD_WORD_ADDR
        |=> rsp_exception == EXC_NONE) else $error("read refused");
    AST_FW_READ: assert property (req_valid && req_func == FN_READ_HOLDING && req_addr == FW_VERSION_ADDR
        |=> rsp_rdata == FW_VERSION) else $error("version read wrong");
    AST_FL_OVERRIDE: assert property (fl_pin [*4] |-> forced_local && !remote_active)
        else $error("forced local input ignored");
    AST_NO_LI1_NO_RUN: assert property (!primary_run_input [*4] |-> !run_cmd)
        else $error("run without first input");
    AST_LI1_FREEWHEEL: assert property ((remote_active && !primary_run_input) [*5] |-> freewheel_stop)
        else $error("no freewheel on first input release");
    AST_MENU_CLOSED: assert property (motor_running |-> !utility_menu_open) else $error("menu open in run");
    AST_FIRST_PRESS: assert property (first_press |=> utility_menu_confirm_prompt && !history_counter_clear)
        else $error("first press did not prompt");
    AST_SECOND_PRESS: assert property (second_press |=> history_counter_clear && !utility_menu_confirm_prompt)
        else $error("second press did not clear");
    AST_BUSY_IGNORED: assert property (utility_menu_enter && !motor_stopped
        |=> !self_test_done && !factory_restore && !history_counter_clear) else $error("utility ran busy");
    AST_TRIP_PULSE: assert property (!req_valid |=> !trip_reset) else $error("trip reset without a write");
endmodule // cca_arbiter_properties

bind cca_command_channel_arbiter cca_arbiter_properties #(.FW_VERSION(FW_VERSION)) chk (
    .clk, .reset, .primary_run_input, .aux_input_two, .aux_input_three, .forced_local_assignment,
    .motor_stopped, .motor_running, .req_valid, .req_func, .req_addr, .rsp_valid, .rsp_exception,
    .rsp_rdata, .utility_menu_item, .utility_menu_enter, .remote_active, .forced_local, .run_cmd, .freewheel_stop,
    .trip_reset, .utility_menu_open, .utility_menu_confirm_prompt, .self_test_done, .factory_restore,
    .history_counter_clear
);

// ### sim/tb.sv
// Testbench of the command channel arbiter: bus, terminal and utility scenarios.
// Assumes the bus master model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module tb;
    import cca_pkg::*;
    `define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
        $display("CHECK FAILED at %0t: got %h expected %h", $time, a, e); end end
    logic clk, reset, primary_run_input, aux_input_two, aux_input_three, motor_stopped, motor_running;
    logic req_valid, rsp_valid, kp_write, utility_menu_enter, remote_active, forced_local, run_cmd, trip_reset;
    logic freewheel_stop, second_param_set, utility_menu_open, utility_menu_confirm_prompt, self_test_done;
    logic self_test_good, factory_restore, history_counter_clear, trip_seen = 1'b0;
    logic [7:0] req_func, rsp_exception, exc;
    logic [15:0] req_addr, req_wdata, rsp_rdata, kp_addr, kp_wdata, firmware_version, rd;
    logic [4:0] self_test_faults;
    cca_fl_assign_t forced_local_assignment;
    cca_utility_menu_item_t utility_menu_item;
    int fail_count = 0, n_tests = 0, cycles = 0;
    logic [15:0] cw [6] = '{16'h0001, 16'h0000, 16'h0400, 16'h0801, 16'h73f7, 16'h73f6};
    logic [2:0] ex [6] = '{3'b100, 3'b000, 3'b010, 3'b101, 3'b100, 3'b000};

    cca_command_channel_arbiter uut (.clk, .reset, .primary_run_input, .aux_input_two, .aux_input_three,
        .forced_local_assignment, .motor_stopped, .motor_running, .req_valid, .req_func, .req_addr,
        .req_wdata, .rsp_valid, .rsp_exception, .rsp_rdata, .kp_write, .kp_addr, .kp_wdata, .utility_menu_item,
        .utility_menu_enter, .self_test_faults, .remote_active, .forced_local, .run_cmd, .freewheel_stop,
        .trip_reset, .second_param_set, .utility_menu_open, .utility_menu_confirm_prompt, .self_test_done,
        .self_test_good, .factory_restore, .history_counter_clear, .firmware_version);
    cca_bus_master master (.clk, .req_valid, .req_func, .req_addr, .req_wdata, .rsp_valid,
        .rsp_exception, .rsp_rdata);

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (trip_reset) trip_seen <= 1'b1;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic bus(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
        master.xfer(f, a, d, exc, rd);
        `CHK(master.ok, 1'b1)
    endtask
    task automatic press(input cca_utility_menu_item_t it);
        @(posedge clk);
        utility_menu_item  <= it;
        utility_menu_enter <= 1'b1;
        @(posedge clk);
        utility_menu_enter <= 1'b0;
        #1;
    endtask
    task automatic pins(input logic run, input logic stop, input logic a2, input logic a3);
        @(posedge clk);
        {primary_run_input, motor_running, aux_input_two, aux_input_three} <= {run, !stop, a2, a3};
        motor_stopped <= stop;
        cyc(4);
    endtask

    initial begin
        reset = 1'b1;
        {primary_run_input, aux_input_two, aux_input_three, motor_running, utility_menu_enter} = '0;
        {kp_write, kp_addr, kp_wdata, self_test_faults} = '0;
        motor_stopped = 1'b1;
        forced_local_assignment = CCA_FL_NONE;
        utility_menu_item = CCA_UT_NONE;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        cyc(1);
        `CHK({rsp_valid, remote_active, utility_menu_open}, 3'b001)
        bus(FN_READ_HOLDING, CHAN_SEL_ADDR, 16'h0000); `CHK(rd, CHAN_LOCAL)
        bus(FN_READ_HOLDING, FW_VERSION_ADDR, 16'h0000); `CHK(rd, FW_VERSION_DEFAULT)
        `CHK(firmware_version, FW_VERSION_DEFAULT)
        bus(FN_WRITE_SINGLE, FW_VERSION_ADDR, 16'h1234); `CHK(exc, EXC_ILLEGAL_ADDR)
        bus(8'h2b, CMD_WORD_ADDR, 16'h0000); `CHK(exc, EXC_ILLEGAL_FUNC)
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        bus(FN_WRITE_SINGLE, CMD_WORD_ADDR, 16'h0000); `CHK(exc, EXC_NONE)
        cyc(2); `CHK(run_cmd, 1'b1)
        pins(1'b1, 1'b0, 1'b0, 1'b0);
        bus(FN_WRITE_SINGLE, CHAN_SEL_ADDR, CHAN_REMOTE);
        bus(FN_READ_HOLDING, CHAN_SEL_ADDR, 16'h0000); `CHK(rd, CHAN_LOCAL)
        `CHK(utility_menu_open, 1'b0)
        press(CCA_UT_SELF_TEST); `CHK(self_test_done, 1'b0)
        pins(1'b1, 1'b1, 1'b0, 1'b0);
        bus(FN_WRITE_SINGLE, CHAN_SEL_ADDR, CHAN_REMOTE); cyc(1); `CHK(remote_active, 1'b1)
        for (int i = 0; i < 6; i++) begin
            bus(i[0] ? FN_WRITE_MULTIPLE : FN_WRITE_SINGLE, CMD_WORD_ADDR, cw[i]);
            cyc(2); `CHK({run_cmd, freewheel_stop, second_param_set}, ex[i])
        end
        bus(FN_WRITE_SINGLE, CMD_WORD_ADDR, 16'h0009); cyc(2); `CHK(trip_seen, 1'b1)
        pins(1'b0, 1'b1, 1'b1, 1'b1); `CHK({run_cmd, freewheel_stop}, 2'b01)
        pins(1'b1, 1'b1, 1'b0, 1'b0); `CHK({run_cmd, freewheel_stop}, 2'b10)
        bus(FN_WRITE_SINGLE, CMD_WORD_ADDR, 16'h8001); cyc(2);
        `CHK({exc, forced_local, remote_active}, {EXC_NONE, 2'b10})
        for (int k = 0; k < 2; k++) begin
            forced_local_assignment <= k ? CCA_FL_AUX_THREE : CCA_FL_AUX_TWO;
            pins(1'b1, 1'b1, !k[0], k[0]); `CHK({forced_local, remote_active}, 2'b10)
            bus(FN_WRITE_SINGLE, CMD_WORD_ADDR, 16'h0001); `CHK(exc, EXC_ILLEGAL_FUNC)
            bus(FN_WRITE_MULTIPLE, CHAN_SEL_ADDR, CHAN_LOCAL); `CHK(exc, EXC_ILLEGAL_FUNC)
            bus(FN_READ_HOLDING, CMD_WORD_ADDR, 16'h0000); `CHK({exc, rd}, {EXC_NONE, 16'h8001})
        end
        pins(1'b1, 1'b1, 1'b1, 1'b0); `CHK(forced_local, 1'b1)
        bus(FN_WRITE_SINGLE, CMD_WORD_ADDR, 16'h0001);
        `CHK({exc, forced_local, remote_active}, {EXC_NONE, 2'b01})
        pins(1'b1, 1'b1, 1'b0, 1'b1); `CHK({forced_local, remote_active}, 2'b10)
        @(posedge clk);
        {kp_write, kp_addr, kp_wdata} <= {1'b1, CHAN_SEL_ADDR, CHAN_LOCAL};
        @(posedge clk);
        kp_write <= 1'b0;
        bus(FN_READ_HOLDING, CHAN_SEL_ADDR, 16'h0000); `CHK({exc, rd}, {EXC_NONE, CHAN_LOCAL})
        press(CCA_UT_SELF_TEST); `CHK({self_test_done, self_test_good}, 2'b11)
        self_test_faults <= 5'h04;
        press(CCA_UT_SELF_TEST); `CHK({self_test_done, self_test_good}, 2'b10)
        press(CCA_UT_HISTORY_CLEAR); `CHK({utility_menu_confirm_prompt, history_counter_clear}, 2'b10)
        press(CCA_UT_HISTORY_CLEAR); `CHK({utility_menu_confirm_prompt, history_counter_clear}, 2'b01)
        press(CCA_UT_HISTORY_CLEAR); `CHK({utility_menu_confirm_prompt, history_counter_clear}, 2'b10)
        press(CCA_UT_FACTORY_RESTORE);
        `CHK({utility_menu_confirm_prompt, factory_restore, history_counter_clear}, 3'b000)
        press(CCA_UT_FACTORY_RESTORE); `CHK({utility_menu_confirm_prompt, factory_restore}, 2'b10)
        press(CCA_UT_FACTORY_RESTORE); `CHK({utility_menu_confirm_prompt, factory_restore}, 2'b01)
        print_verdict();
    end
endmodule // tb
